// ### core/sbx_exec.sv
// Our own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Functional notes
// - literal shift: arithmetic right of base register by 4-bit literal, word only
// - register shift: amount register gives the count, saturating at 16 above 15
// - both shifts update only negative and zero flags
// - file bit clear: bit index split at word ends, flags untouched
// - register bit clear: bit index, byte select, mode and register fields
// - bit 0 is least significant, up to 7 for byte or 15 for word
// - select bit clear means word, set means byte
// - register bit clear operand may be direct or indirect with inc/dec
// - unconditional branch: pc+2 plus twice signed offset, two cycles
// - computed branch: pc+2 plus twice register, 17-bit sign extended, two cycles
// - carry branch: taken when carry set in two cycles, else one cycle
module sbx_exec
  import sbx_pkg::*;
(
  input wire logic ref_clk, // core clock
  input wire logic srst, // synchronous reset, high
  input wire logic [31:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [31:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready // read data ready
);

  // working registers, data memory, pc, status
  logic [15:0] wreg_r [16];
  logic [15:0] mem_r [SBX_MEM_WORDS];
  logic [22:0] pc_r;
  logic [15:0] sr_r;
  logic [23:0] instr_r;
  logic [3:0] wsel_r;
  logic [SBX_MADR_W-1:0] madr_r;
  sbx_state_t state_r;
  logic [31:0] aw_addr_r;
  logic aw_have_r;
  sbx_wreq_t wq_r;
  logic w_have_r;

  // arithmetic right shift of a word, count saturating at 16
  function automatic logic [15:0] sbx_asr(input logic [15:0] v, input logic [4:0] n);
    logic [31:0] ext;
    ext = {{16{v[15]}}, v};
    sbx_asr = n[4] ? {16{v[15]}} : 16'(ext >> n);
  endfunction

  // clear one bit; byte mode confines index to the low byte
  function automatic logic [15:0] sbx_bit_clear_op(input logic [15:0] v, input logic [3:0] b, input logic byt);
    logic [15:0] m;
    m = 16'h0001 << (byt ? {1'b0, b[2:0]} : b);
    sbx_bit_clear_op = v & ~m;
  endfunction

  // offset within the map; any upper address bit sends it to an unused offset
  function automatic logic [7:0] sbx_off(input logic [31:0] a);
    sbx_off = (a[31:8] == 24'h000000) ? a[7:0] : 8'hFF;
  endfunction

  // slave error for offsets past the map or off a word boundary
  function automatic logic [1:0] sbx_resp(input logic [7:0] off);
    sbx_resp = (off > SBX_MDAT_OFF || off[1:0] != 2'h0) ? 2'h2 : 2'h0;
  endfunction

  // instruction fields
  logic [7:0] op_hi;
  logic [3:0] f_wb, f_wd, f_ws, f_k;
  logic [15:0] s_off;
  logic byt_sel;
  logic [2:0] am;
  logic [3:0] bidx;
  logic [12:0] faddr;
  logic [3:0] bidx_f;
  assign op_hi = instr_r[23:16];
  assign f_wb = instr_r[14:11];
  assign f_wd = instr_r[10:7];
  assign f_ws = instr_r[3:0];
  assign f_k = instr_r[3:0];
  assign s_off = instr_r[15:0];
  assign byt_sel = instr_r[10];
  assign am = instr_r[6:4];
  assign bidx = instr_r[15:12];
  assign faddr = {instr_r[12:1], 1'b0};
  assign bidx_f = {instr_r[15:13], instr_r[0]};

  // decode
  logic is_shl, is_shr, is_bcf, is_bcw, is_bra, is_brc, is_braw;
  assign is_shl = op_hi == SBX_OP_SHIFT && instr_r[6:4] == SBX_SH_LIT[2:0] && instr_r[15];
  assign is_shr = op_hi == SBX_OP_SHIFT && instr_r[6:4] == SBX_SH_REG[2:0] && instr_r[15];
  assign is_bcf = op_hi == SBX_OP_BCLRF;
  assign is_bcw = op_hi == SBX_OP_BCLRW && instr_r[11] == 1'b0 && instr_r[9:7] == 3'b000;
  assign is_bra = op_hi == SBX_OP_BRA;
  assign is_brc = op_hi == SBX_OP_BRAC;
  assign is_braw = instr_r[23:12] == SBX_OP_BRAW && instr_r[11:4] == 8'h00;

  // bus write handshake
  logic wr_fire, rd_fire, go;
  logic [7:0] woff;
  logic [7:0] roff;
  assign wr_fire = aw_have_r && w_have_r && !s_axi_bvalid;
  assign woff = sbx_off(aw_addr_r);
  assign go = wr_fire && woff == SBX_CTRL_OFF && wq_r.data[0] && state_r == SBX_ST_IDLE;
  // read offset, decoded while the request address still stands
  assign roff = sbx_off(s_axi_araddr);
  assign rd_fire = s_axi_arvalid && s_axi_arready;

  // shift results
  logic [15:0] sh_res, amt;
  assign amt = wreg_r[f_ws];
  always_comb begin
    if (is_shl) begin
      sh_res = sbx_asr(wreg_r[f_wb], {1'b0, f_k});
    end else begin
      sh_res = sbx_asr(wreg_r[f_wb], (amt > 16'h000F) ? 5'h10 : {1'b0, amt[3:0]});
    end
  end

  // register bit clear operand address with pre/post adjust
  logic [15:0] ea, wadj;
  logic [15:0] step;
  assign step = byt_sel ? 16'h0001 : 16'h0002;
  always_comb begin
    ea = wreg_r[f_ws];
    wadj = wreg_r[f_ws];
    case (am)
      SBX_AM_POSTINC: wadj = wreg_r[f_ws] + step;
      SBX_AM_POSTDEC: wadj = wreg_r[f_ws] - step;
      SBX_AM_PREINC: begin
        ea = wreg_r[f_ws] + step;
        wadj = ea;
      end
      SBX_AM_PREDEC: begin
        ea = wreg_r[f_ws] - step;
        wadj = ea;
      end
      default: ;
    endcase
  end

  // memory word index for a byte address
  function automatic logic [SBX_MADR_W-1:0] sbx_idx(input logic [15:0] a);
    sbx_idx = a[SBX_MADR_W:1];
  endfunction

  // branch target computation
  logic [22:0] pc_inc, br_tgt;
  assign pc_inc = pc_r + 23'h000002;
  always_comb begin
    if (is_braw) begin
      br_tgt = pc_inc + 23'({{6{wreg_r[f_ws][15]}}, wreg_r[f_ws], 1'b0});
    end else begin
      br_tgt = pc_inc + 23'({{6{s_off[15]}}, s_off, 1'b0});
    end
  end

  // always taken for the two unconditional forms, on carry for the third
  logic taken;
  assign taken = is_bra || is_braw || (is_brc && sr_r[SBX_SR_C]);

  // sequencer: second cycle of a taken branch runs a no-operation
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_r <= SBX_ST_IDLE;
    end else begin
      case (state_r)
        SBX_ST_IDLE: if (go && taken) state_r <= SBX_ST_NOP;
        SBX_ST_NOP: state_r <= SBX_ST_IDLE;
        default: state_r <= SBX_ST_IDLE;
      endcase
    end
  end

  // program counter
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pc_r <= SBX_PC_RST;
    end else if (go) begin
      pc_r <= taken ? br_tgt : pc_inc;
    end else if (wr_fire && woff == SBX_PC_OFF) begin
      pc_r <= wq_r.data[22:0];
    end
  end

  // status word: shifts touch N and Z only, others never
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sr_r <= SBX_SR_RST;
    end else if (go && (is_shl || is_shr)) begin
      sr_r[SBX_SR_N] <= sh_res[15];
      sr_r[SBX_SR_Z] <= sh_res == 16'h0000;
    end else if (wr_fire && woff == SBX_SR_OFF) begin
      sr_r <= wq_r.data[15:0]; // branches never reach here
    end
  end

  // working registers
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      for (int i = 0; i < 16; i++) wreg_r[i] <= 16'h0000;
    end else if (go && (is_shl || is_shr)) begin
      wreg_r[f_wd] <= sh_res;
    end else if (go && is_bcw) begin
      if (am == SBX_AM_DIR) begin
        wreg_r[f_ws] <= sbx_bit_clear_op(wreg_r[f_ws], bidx, byt_sel);
      end else begin
        wreg_r[f_ws] <= wadj;
      end
    end else if (wr_fire && woff == SBX_WDAT_OFF) begin
      wreg_r[wsel_r] <= wq_r.data[15:0];
    end
  end

  // data memory; byte clears act on the addressed lane
  logic [15:0] mword_ind, mword_f;
  logic [3:0] lane_b;
  assign mword_ind = mem_r[sbx_idx(ea)];
  assign mword_f = mem_r[sbx_idx({3'b000, faddr})];
  assign lane_b = {ea[0], bidx[2:0]};
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      for (int i = 0; i < SBX_MEM_WORDS; i++) mem_r[i] <= 16'h0000;
    end else if (go && is_bcf) begin
      mem_r[sbx_idx({3'b000, faddr})] <= sbx_bit_clear_op(mword_f, instr_r[1] ? {1'b1, bidx_f[2:0]} : bidx_f,
                                                  1'b0);
    end else if (go && is_bcw && am != SBX_AM_DIR) begin
      mem_r[sbx_idx(ea)] <= sbx_bit_clear_op(mword_ind, byt_sel ? lane_b : bidx, 1'b0);
    end else if (wr_fire && woff == SBX_MDAT_OFF) begin
      mem_r[madr_r] <= wq_r.data[15:0];
    end
  end

  // software-written instruction and selectors
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      instr_r <= 24'h000000;
      wsel_r <= 4'h0;
      madr_r <= '0;
    end else begin
      if (wr_fire && woff == SBX_INSTR_OFF) instr_r <= wq_r.data[23:0];
      if (wr_fire && woff == SBX_WSEL_OFF) wsel_r <= wq_r.data[3:0];
      if (wr_fire && woff == SBX_MADR_OFF) madr_r <= wq_r.data[SBX_MADR_W-1:0];
    end
  end

  // write channels, taken in either order
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_addr_r <= 32'h00000000;
      wq_r <= '0;
      s_axi_bvalid <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        wq_r <= '{addr: 32'h00000000, data: s_axi_wdata, strb: s_axi_wstrb};
      end
      if (wr_fire) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  // ready only while the slot is empty and no response waits
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_have_r && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready <= !w_have_r && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
    end
  end

  // read channel
  logic [31:0] rd_mux;
  always_comb begin
    case (roff)
      SBX_INSTR_OFF: rd_mux = {8'h00, instr_r};
      SBX_CTRL_OFF: rd_mux = {31'h0, state_r != SBX_ST_IDLE};
      SBX_PC_OFF: rd_mux = {9'h0, pc_r};
      SBX_SR_OFF: rd_mux = {16'h0000, sr_r};
      SBX_WSEL_OFF: rd_mux = {28'h0000000, wsel_r};
      SBX_WDAT_OFF: rd_mux = {16'h0000, wreg_r[wsel_r]};
      SBX_MADR_OFF: rd_mux = {26'h0, madr_r};
      SBX_MDAT_OFF: rd_mux = {16'h0000, mem_r[madr_r]};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // read address acceptance and response, data captured as the request is taken
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !rd_fire;
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= sbx_resp(roff);
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // write response code, set with the write itself
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_axi_bresp <= 2'h0;
    end else if (wr_fire) begin
      s_axi_bresp <= sbx_resp(woff);
    end
  end

endmodule

// ### core/sbx_pkg.sv
package sbx_pkg;
  // register bus offsets
  localparam logic [7:0] SBX_INSTR_OFF = 8'h00;
  localparam logic [7:0] SBX_CTRL_OFF = 8'h04;
  localparam logic [7:0] SBX_PC_OFF = 8'h08;
  localparam logic [7:0] SBX_SR_OFF = 8'h0C;
  localparam logic [7:0] SBX_WSEL_OFF = 8'h10;
  localparam logic [7:0] SBX_WDAT_OFF = 8'h14;
  localparam logic [7:0] SBX_MADR_OFF = 8'h18;
  localparam logic [7:0] SBX_MDAT_OFF = 8'h1C;
  // status word bit positions
  localparam int SBX_SR_C = 0;
  localparam int SBX_SR_Z = 1;
  localparam int SBX_SR_N = 3;
  // reset values
  localparam logic [22:0] SBX_PC_RST = 23'h000000;
  localparam logic [15:0] SBX_SR_RST = 16'h0000;
  // opcode patterns
  localparam logic [7:0] SBX_OP_SHIFT = 8'hDE;
  localparam logic [3:0] SBX_SH_LIT = 4'h4;
  localparam logic [3:0] SBX_SH_REG = 4'h0;
  localparam logic [7:0] SBX_OP_BCLRF = 8'hA9;
  localparam logic [7:0] SBX_OP_BCLRW = 8'hA1;
  localparam logic [7:0] SBX_OP_BRA = 8'h37;
  localparam logic [7:0] SBX_OP_BRAC = 8'h31;
  localparam logic [11:0] SBX_OP_BRAW = 12'h016;
  localparam int SBX_MEM_WORDS = 64;
  localparam int SBX_MADR_W = 6;
  // addressing modes
  typedef enum logic [2:0] {
    SBX_AM_DIR = 3'b000,
    SBX_AM_IND = 3'b001,
    SBX_AM_POSTINC = 3'b010,
    SBX_AM_POSTDEC = 3'b011,
    SBX_AM_PREINC = 3'b100,
    SBX_AM_PREDEC = 3'b101
  } sbx_am_t;
  typedef enum logic [1:0] {
    SBX_ST_IDLE = 2'b00,
    SBX_ST_NOP = 2'b01
  } sbx_state_t;
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } sbx_wreq_t;
endpackage

// ### bench/sbx_monitor.sv
`timescale 1ns/1ps
module sbx_monitor
  import sbx_pkg::*;
(
  input wire logic ref_clk, // clock
  input wire logic srst, // reset
  input wire logic [31:0] s_axi_awaddr, // aw
  input wire logic s_axi_awvalid, // aw
  input wire logic s_axi_awready, // aw
  input wire logic [31:0] s_axi_wdata, // w
  input wire logic [3:0] s_axi_wstrb, // w
  input wire logic s_axi_wvalid, // w
  input wire logic s_axi_wready, // w
  input wire logic [1:0] s_axi_bresp, // b
  input wire logic s_axi_bvalid, // b
  input wire logic s_axi_bready, // b
  input wire logic [31:0] s_axi_araddr, // ar
  input wire logic s_axi_arvalid, // ar
  input wire logic s_axi_arready, // ar
  input wire logic [31:0] s_axi_rdata, // r
  input wire logic [1:0] s_axi_rresp, // r
  input wire logic s_axi_rvalid, // r
  input wire logic s_axi_rready // r
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  logic [31:0] aw_q;
  logic [31:0] ar_q;
  // remember addresses of accepted requests
  always_ff @(posedge ref_clk) begin
    if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
    if (s_axi_arvalid && s_axi_arready) ar_q <= s_axi_araddr;
  end
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read response dropped");
  property p_r_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_r_answer: assert property (p_r_answer) else $error("read answer late");
  property p_b_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_b_answer: assert property (p_b_answer) else $error("write answer late");
  property p_r_err; s_axi_rvalid && ar_q > 32'h1C |-> s_axi_rresp == 2'h2; endproperty
  a_r_err: assert property (p_r_err) else $error("unmapped read not refused");
  property p_r_ok; s_axi_rvalid && ar_q <= 32'h1C && ar_q[1:0] == 2'h0 |-> s_axi_rresp == 2'h0; endproperty
  a_r_ok: assert property (p_r_ok) else $error("mapped read refused");
  property p_b_err; s_axi_bvalid && aw_q > 32'h1C |-> s_axi_bresp == 2'h2; endproperty
  a_b_err: assert property (p_b_err) else $error("unmapped write not refused");
  property p_sr_bits; s_axi_rvalid && ar_q == {24'h0, SBX_SR_OFF} |-> s_axi_rdata[31:4] == 28'h0 && !s_axi_rdata[2];
  endproperty
  a_sr_bits: assert property (p_sr_bits) else $error("stray status bit");
endmodule

bind sbx_exec sbx_monitor mon_u (.ref_clk, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
  .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

// ### bench/sbx_host.sv
`timescale 1ns/1ps
module sbx_host (
  input wire logic ref_clk, // clock
  output logic [31:0] s_axi_awaddr, // aw
  output logic s_axi_awvalid, // aw
  input wire logic s_axi_awready, // aw
  output logic [31:0] s_axi_wdata, // w
  output logic s_axi_wvalid, // w
  input wire logic s_axi_wready, // w
  input wire logic s_axi_bvalid, // b
  output logic s_axi_bready, // b
  output logic [31:0] s_axi_araddr, // ar
  output logic s_axi_arvalid, // ar
  input wire logic s_axi_arready, // ar
  input wire logic [31:0] s_axi_rdata, // r
  input wire logic [1:0] s_axi_rresp, // r
  input wire logic s_axi_rvalid, // r
  output logic s_axi_rready // r
);
  // bus idle at time zero
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
  end
  // one write, each channel released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 50);
    s_axi_bready <= 1'b0;
    if (!s_axi_bvalid) tb.hang();
  endtask
  // one read, data taken at the answering edge
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge ref_clk);
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 50);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (!s_axi_rvalid) tb.hang();
  endtask
endmodule

// ### bench/tb.sv
`timescale 1ns/1ps
module tb
  import sbx_pkg::*;
;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [22:0] epc = 23'h0;
  int errors = 0;
  int total_checks = 0;
  sbx_exec dut_u (.ref_clk, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  sbx_host host_u (.ref_clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic hang();
    errors++;
    $display("mismatch at %0t: bus wait ran out", $time);
    conclude();
  endtask
  // register helpers
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    host_u.rd(a, d, r);
    chk(d, exp);
  endtask
  task automatic setw(input logic [3:0] i, input logic [31:0] v);
    host_u.wr(SBX_WSEL_OFF, {28'h0, i});
    host_u.wr(SBX_WDAT_OFF, v);
  endtask
  task automatic getw(input logic [3:0] i, input logic [31:0] exp);
    host_u.wr(SBX_WSEL_OFF, {28'h0, i});
    rdchk(SBX_WDAT_OFF, exp);
  endtask
  task automatic setm(input logic [5:0] i, input logic [31:0] v);
    host_u.wr(SBX_MADR_OFF, {26'h0, i});
    host_u.wr(SBX_MDAT_OFF, v);
  endtask
  task automatic getm(input logic [5:0] i, input logic [31:0] exp);
    host_u.wr(SBX_MADR_OFF, {26'h0, i});
    rdchk(SBX_MDAT_OFF, exp);
  endtask
  task automatic run(input logic [23:0] ins);
    host_u.wr(SBX_INSTR_OFF, {8'h0, ins});
    host_u.wr(SBX_CTRL_OFF, 32'h1);
    epc = epc + 23'h2;
  endtask
  // reset values and an unmapped place
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0] r;
    rdchk(SBX_PC_OFF, 32'h0);
    rdchk(SBX_SR_OFF, 32'h0);
    host_u.rd(8'h20, d, r);
    chk({30'h0, r}, 32'h2);
    host_u.wr(8'h20, 32'h0); // unmapped write, answered with a slave error
  endtask
  // both shift forms, flags and saturation
  task automatic t_shift();
    host_u.wr(SBX_SR_OFF, 32'h1);
    setw(4'h0, 32'h80FF);
    run({8'hDE, 1'b1, 4'h0, 4'h1, 3'h4, 4'h6});
    getw(4'h1, 32'hFE03);
    rdchk(SBX_SR_OFF, 32'h9);
    setw(4'h5, 32'h0004);
    run({8'hDE, 1'b1, 4'h0, 4'h6, 3'h0, 4'h5});
    getw(4'h6, 32'hF80F);
    setw(4'h2, 32'h70FF);
    run({8'hDE, 1'b1, 4'h2, 4'h3, 3'h4, 4'hF});
    getw(4'h3, 32'h0);
    rdchk(SBX_SR_OFF, 32'h3);
    setw(4'h5, 32'h88E4);
    setw(4'h7, 32'h8765);
    run({8'hDE, 1'b1, 4'h7, 4'h8, 3'h0, 4'h5});
    getw(4'h8, 32'hFFFF);
  endtask
  // register and file bit clears, direct and indirect
  task automatic t_bit_clear_op();
    setw(4'h2, 32'hF234);
    run({8'hA1, 4'hF, 1'b0, 1'b0, 3'h0, SBX_AM_DIR, 4'h2});
    getw(4'h2, 32'h7234);
    run({8'hA1, 4'h2, 1'b0, 1'b1, 3'h0, SBX_AM_DIR, 4'h2});
    getw(4'h2, 32'h7230);
    setw(4'h0, 32'h0010); // aligned word address
    setm(6'h08, 32'h5607);
    run({8'hA1, 4'h0, 1'b0, 1'b0, 3'h0, SBX_AM_POSTINC, 4'h0});
    getm(6'h08, 32'h5606);
    getw(4'h0, 32'h0012);
    setw(4'h4, 32'h0016);
    setm(6'h0A, 32'hFFFF);
    run({8'hA1, 4'h7, 1'b0, 1'b1, 3'h0, SBX_AM_PREDEC, 4'h4}); // byte index 7
    getm(6'h0A, 32'h7FFF);
    getw(4'h4, 32'h0015);
    setm(6'h05, 32'hFFFF);
    run({8'hA9, 3'h5, 12'h005, 1'b1});
    getm(6'h05, 32'hF7FF);
    rdchk(SBX_SR_OFF, 32'h9);
  endtask
  // branches: relative, computed, on carry
  task automatic t_branch();
    logic [31:0] d;
    logic [1:0] r;
    host_u.wr(SBX_INSTR_OFF, {8'h0, 8'h37, 16'h0003});
    // read the busy flag during the no-operation cycle of the taken branch
    fork
      host_u.wr(SBX_CTRL_OFF, 32'h1);
      begin
        repeat (2) @(posedge ref_clk);
        host_u.rd(SBX_CTRL_OFF, d, r);
      end
    join
    chk(d, 32'h1);
    epc = epc + 23'h8;
    rdchk(SBX_PC_OFF, {9'h0, epc});
    run({8'h37, 16'hFFFE});
    epc = epc - 23'h4;
    rdchk(SBX_PC_OFF, {9'h0, epc});
    rdchk(SBX_CTRL_OFF, 32'h0);
    setw(4'h7, 32'h0084);
    run({12'h016, 8'h00, 4'h7});
    epc = epc + 23'h108;
    rdchk(SBX_PC_OFF, {9'h0, epc});
    setw(4'h7, 32'hFFFE);
    run({12'h016, 8'h00, 4'h7});
    epc = epc - 23'h4;
    rdchk(SBX_PC_OFF, {9'h0, epc});
    rdchk(SBX_SR_OFF, 32'h9);
    host_u.wr(SBX_SR_OFF, 32'h0);
    run({8'h31, 16'h0005});
    rdchk(SBX_PC_OFF, {9'h0, epc});
    host_u.wr(SBX_SR_OFF, 32'h1);
    run({8'h31, 16'h0005});
    epc = epc + 23'hA;
    rdchk(SBX_PC_OFF, {9'h0, epc});
    rdchk(SBX_SR_OFF, 32'h1);
  endtask
  // free-running clock
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  // main sequence
  initial begin
    repeat (3) @(posedge ref_clk);
    srst <= 1'b0;
    t_reset();
    t_shift();
    t_bit_clear_op();
    t_branch();
    conclude();
  end
endmodule
